/* File: rtl/gsr_pkg.sv */
// Shared constants for the gesture sensor register bank and its host.
package gsr_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h73;
    localparam logic [7:0] OFS_SUSPEND = 8'h03;
    localparam logic [7:0] OFS_G_MASK = 8'h41;
    localparam logic [7:0] OFS_GP_MASK = 8'h42;
    localparam logic [7:0] OFS_G_FLAGS = 8'h43;
    localparam logic [7:0] OFS_GP_FLAGS = 8'h44;
    localparam logic [7:0] OFS_G_STATE = 8'h45;
    localparam logic [7:0] OFS_PROX_HIGH = 8'h69;
    localparam logic [7:0] OFS_PROX_LOW = 8'h6a;
    localparam logic [7:0] OFS_APPROACH = 8'h6b;
    localparam logic [7:0] OFS_PROX_DATA = 8'h6c;
    localparam logic [7:0] OFS_BRIGHT = 8'hb0;
    localparam logic [7:0] OFS_SIZE_LO = 8'hb1;
    localparam logic [7:0] OFS_SIZE_HI = 8'hb2;
    localparam logic [7:0] OFS_BANK_SEL = 8'hef;
    localparam logic [7:0] OFS_B1_GAIN = 8'h44;
    localparam logic [7:0] SUSPEND_CMD = 8'h01;
    localparam logic [7:0] RST_SUSPEND = 8'h01;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_PROX_HIGH = 8'hc8;
    localparam logic [7:0] RST_PROX_LOW = 8'h40;
    localparam logic [7:0] RST_B1_GAIN = 8'ha0;
    localparam logic [7:0] RST_BANK_SEL = 8'h00;
    localparam logic [7:0] BANK0 = 8'h00;
    localparam logic [7:0] BANK1 = 8'h01;
    // System clock cycles per quarter of an SCL period (20 MHz / 200 = 100 kHz).
    localparam int SCL_QTR_CYCLES = 50;
endpackage

/* File: rtl/gsr_if.sv */
// Open-drain I2C and interrupt wires joining the host and the sensor.
`timescale 1ns/1ps
`default_nettype none
interface gsr_if;
    logic scl_h_o;
    logic scl_h_oe;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic int_d_o;
    logic int_d_oe;
    logic scl;
    logic sda;
    logic int_n;

    // Pulled-up wires: low only while an enabled driver pulls low.
    assign scl = ~(scl_h_oe & ~scl_h_o);
    assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
    assign int_n = ~(int_d_oe & ~int_d_o);

    modport dev (input scl, input sda, output sda_d_o, output sda_d_oe,
                 output int_d_o, output int_d_oe);
    modport host (input scl, input sda, input int_n, output scl_h_o, output scl_h_oe,
                  output sda_h_o, output sda_h_oe);
endinterface
`default_nettype wire

/* File: rtl/gsr_device.sv */
// Sensor end: I2C target with the two-bank register map and proximity hysteresis.
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Answer I2C only at seven-bit address 0x73.
// - Writing 0x01 to suspend_command enters suspend.
// - Own address on bus wakes from suspend.
// - Writing 01 to bank_select selects bank 1.
// - Approach set when data at/above high threshold.
// - Approach cleared only at/below low threshold.
// - High threshold prox_high_threshold, read/write, default 0xC8.
// - Low threshold prox_low_threshold, read/write, default 0x40.
// - Masks at gesture_irq_mask and gesture_prox_irq_mask, default 0xFF.
// - Event flags readable at gesture_irq_flags and the gesture-proximity flag register (bank 0, 0x44).
// - Gesture state readable at gesture_state_indicator.
// - Proximity data readable at prox_data.
// - Brightness readable at object_brightness, max 255.
// - Ten-bit size readable at object_size_low/object_size_high.
// - Bank 1 gain at bank1_prox_gain, default 0xA0.
module gsr_device (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // I2C and interrupt pins
    gsr_if.dev pins,
    // Sensor core
    input wire logic prox_mode_i,
    input wire logic gesture_mode_i,
    input wire logic [7:0] prox_data_i,
    input wire logic [7:0] gesture_set_i,
    input wire logic [7:0] gprox_set_i,
    input wire logic [7:0] gesture_state_i,
    input wire logic [7:0] brightness_i,
    input wire logic [9:0] size_i,
    output logic suspend_o,
    output logic approach_o,
    output logic [7:0] prox_gain_o
);
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_ADDR = 3'b001,
        D_ACK = 3'b010,
        D_WR = 3'b011,
        D_RD = 3'b100,
        D_RACK = 3'b101
    } gsr_dstate_t;

    gsr_dstate_t state_r;
    logic scl_q_r;
    logic sda_q_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] ptr_r;
    logic first_r;
    logic rw_r;
    logic sda_oe_r;
    logic int_oe_r;
    logic suspended_r;
    logic approach_r;
    logic [7:0] suspend_cmd_r;
    logic [7:0] g_mask_r;
    logic [7:0] gp_mask_r;
    logic [7:0] g_flags_r;
    logic [7:0] gp_flags_r;
    logic [7:0] high_r;
    logic [7:0] low_r;
    logic [7:0] bank_r;
    logic [7:0] gain_r;

    // Bus events seen on the synchronously sampled pins.
    wire scl_rise = pins.scl & ~scl_q_r;
    wire scl_fall = ~pins.scl & scl_q_r;
    wire start_ev = pins.scl & scl_q_r & sda_q_r & ~pins.sda;
    wire stop_ev = pins.scl & scl_q_r & ~sda_q_r & pins.sda;
    wire addr_hit = (sh_r[7:1] == gsr_pkg::TARGET_ADDR);
    wire byte_done = (cnt_r == 4'h8);
    wire wr_fire = scl_fall & (state_r == D_WR) & byte_done & ~first_r;
    wire ack_rd_load = scl_fall & (state_r == D_ACK) & rw_r;
    wire rack_load = scl_fall & (state_r == D_RACK);
    wire rd_fire = ack_rd_load | rack_load;
    wire bank0 = (bank_r == gsr_pkg::BANK0);
    wire bank1 = (bank_r == gsr_pkg::BANK1);

    // Write decode; the bank select answers in every bank.
    wire wr_bank = wr_fire & (ptr_r == gsr_pkg::OFS_BANK_SEL);
    wire wr_susp = wr_fire & bank0 & (ptr_r == gsr_pkg::OFS_SUSPEND);
    wire wr_gmask = wr_fire & bank0 & (ptr_r == gsr_pkg::OFS_G_MASK);
    wire wr_gpmask = wr_fire & bank0 & (ptr_r == gsr_pkg::OFS_GP_MASK);
    wire wr_high = wr_fire & bank0 & (ptr_r == gsr_pkg::OFS_PROX_HIGH);
    wire wr_low = wr_fire & bank0 & (ptr_r == gsr_pkg::OFS_PROX_LOW);
    wire wr_gain = wr_fire & bank1 & (ptr_r == gsr_pkg::OFS_B1_GAIN);
    // Reading a flag register clears the flags that were reported.
    wire clr_g = rd_fire & bank0 & (ptr_r == gsr_pkg::OFS_G_FLAGS);
    wire clr_gp = rd_fire & bank0 & (ptr_r == gsr_pkg::OFS_GP_FLAGS);

    // The gesture state only means something in gesture mode, so it reads as zero otherwise.
    wire [7:0] g_state_rd = gesture_mode_i ? gesture_state_i : 8'h00;

    // Read decode for the byte at the pointer.
    wire [7:0] rd_b0 =
        (ptr_r == gsr_pkg::OFS_SUSPEND) ? suspend_cmd_r :
        (ptr_r == gsr_pkg::OFS_G_MASK) ? g_mask_r :
        (ptr_r == gsr_pkg::OFS_GP_MASK) ? gp_mask_r :
        (ptr_r == gsr_pkg::OFS_G_FLAGS) ? g_flags_r :
        (ptr_r == gsr_pkg::OFS_GP_FLAGS) ? gp_flags_r :
        (ptr_r == gsr_pkg::OFS_G_STATE) ? g_state_rd :
        (ptr_r == gsr_pkg::OFS_PROX_HIGH) ? high_r :
        (ptr_r == gsr_pkg::OFS_PROX_LOW) ? low_r :
        (ptr_r == gsr_pkg::OFS_APPROACH) ? {7'h00, approach_r} :
        (ptr_r == gsr_pkg::OFS_PROX_DATA) ? prox_data_i :
        (ptr_r == gsr_pkg::OFS_BRIGHT) ? brightness_i :
        (ptr_r == gsr_pkg::OFS_SIZE_LO) ? size_i[7:0] :
        (ptr_r == gsr_pkg::OFS_SIZE_HI) ? {6'h00, size_i[9:8]} : 8'h00;
    wire [7:0] rd_b1 = (ptr_r == gsr_pkg::OFS_B1_GAIN) ? gain_r : 8'h00;
    wire [7:0] rd_data = (ptr_r == gsr_pkg::OFS_BANK_SEL) ? bank_r :
                         bank1 ? rd_b1 : bank0 ? rd_b0 : 8'h00;

    // Hysteresis only tracks in proximity mode while awake.
    wire prox_live = prox_mode_i & ~suspended_r;
    wire at_high = prox_data_i >= high_r;
    wire at_low = prox_data_i <= low_r;

    assign pins.sda_d_o = 1'b0;
    assign pins.sda_d_oe = sda_oe_r;
    assign pins.int_d_o = 1'b0;
    assign pins.int_d_oe = int_oe_r;
    assign suspend_o = suspended_r;
    assign approach_o = approach_r;
    assign prox_gain_o = gain_r;

    // Bit-level target engine.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state_r <= D_IDLE;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            first_r <= 1'b1;
            rw_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            scl_q_r <= pins.scl;
            sda_q_r <= pins.sda;
            if (start_ev)
            begin
                state_r <= D_ADDR;
                cnt_r <= 4'h0;
                first_r <= 1'b1;
                sda_oe_r <= 1'b0;
            end
            else if (stop_ev)
            begin
                state_r <= D_IDLE;
                sda_oe_r <= 1'b0;
            end
            else if (scl_rise)
            begin
                if ((state_r == D_ADDR) || (state_r == D_WR))
                begin
                    sh_r <= {sh_r[6:0], pins.sda};
                    cnt_r <= cnt_r + 4'h1;
                end
                else if ((state_r == D_RACK) && pins.sda)
                    state_r <= D_IDLE;
            end
            else if (scl_fall)
            begin
                case (state_r)
                    D_ADDR:
                        if (byte_done)
                        begin
                            state_r <= addr_hit ? D_ACK : D_IDLE;
                            sda_oe_r <= addr_hit;
                            rw_r <= sh_r[0];
                        end
                    D_WR:
                        if (byte_done)
                        begin
                            if (first_r)
                                ptr_r <= sh_r;
                            else
                                ptr_r <= ptr_r + 8'h01;
                            first_r <= 1'b0;
                            sda_oe_r <= 1'b1;
                            state_r <= D_ACK;
                        end
                    D_ACK, D_RACK:
                        if (rw_r)
                        begin
                            sh_r <= rd_data;
                            sda_oe_r <= ~rd_data[7];
                            ptr_r <= ptr_r + 8'h01;
                            cnt_r <= 4'h1;
                            state_r <= D_RD;
                        end
                        else
                        begin
                            sda_oe_r <= 1'b0;
                            cnt_r <= 4'h0;
                            state_r <= D_WR;
                        end
                    D_RD:
                        if (byte_done)
                        begin
                            sda_oe_r <= 1'b0;
                            state_r <= D_RACK;
                        end
                        else
                        begin
                            sda_oe_r <= ~sh_r[6];
                            sh_r <= {sh_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    default:
                        state_r <= D_IDLE;
                endcase
            end
        end
    end

    // Register bank, event flags, suspend and hysteresis.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            suspend_cmd_r <= gsr_pkg::RST_SUSPEND;
            g_mask_r <= gsr_pkg::RST_MASK;
            gp_mask_r <= gsr_pkg::RST_MASK;
            high_r <= gsr_pkg::RST_PROX_HIGH;
            low_r <= gsr_pkg::RST_PROX_LOW;
            gain_r <= gsr_pkg::RST_B1_GAIN;
            bank_r <= gsr_pkg::RST_BANK_SEL;
            g_flags_r <= 8'h00;
            gp_flags_r <= 8'h00;
            suspended_r <= 1'b0;
            approach_r <= 1'b0;
            int_oe_r <= 1'b0;
        end
        else
        begin
            if (wr_susp) suspend_cmd_r <= sh_r;
            if (wr_gmask) g_mask_r <= sh_r;
            if (wr_gpmask) gp_mask_r <= sh_r;
            if (wr_high) high_r <= sh_r;
            if (wr_low) low_r <= sh_r;
            if (wr_gain) gain_r <= sh_r;
            if (wr_bank) bank_r <= sh_r;
            // A new event in the clearing cycle survives the clear.
            g_flags_r <= (clr_g ? 8'h00 : g_flags_r) | gesture_set_i;
            gp_flags_r <= (clr_gp ? 8'h00 : gp_flags_r) | gprox_set_i;
            if (scl_fall && (state_r == D_ADDR) && byte_done && addr_hit)
                suspended_r <= 1'b0;
            else if (wr_susp && (sh_r == gsr_pkg::SUSPEND_CMD))
                suspended_r <= 1'b1;
            if (prox_live && at_high)
                approach_r <= 1'b1;
            else if (prox_live && at_low)
                approach_r <= 1'b0;
            int_oe_r <= |(g_flags_r & g_mask_r) | |(gp_flags_r & gp_mask_r);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/gsr_host.sv */
// Host end: I2C controller that reads and writes single sensor registers.
`timescale 1ns/1ps
`default_nettype none
module gsr_host #(
    parameter int QTR = gsr_pkg::SCL_QTR_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // I2C and interrupt pins
    gsr_if.host pins,
    // Command port
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_reg_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic cmd_ready_o,
    // Response port
    output logic rsp_valid_o,
    output logic rsp_nack_o,
    output logic [7:0] rsp_rdata_o,
    // Sensor interrupt, active high
    output logic irq_o
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_BIT = 3'b010,
        H_STOP = 3'b011
    } gsr_hstate_t;

    gsr_hstate_t state_r;
    logic [15:0] tick_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [1:0] idx_r;
    logic [8:0] tx_r;
    logic [8:0] rx_r;
    logic write_r;
    logic [7:0] reg_r;
    logic [7:0] wdata_r;
    logic scl_oe_r;
    logic sda_oe_r;
    logic nack_r;
    logic rsp_r;
    logic [7:0] rdata_r;

    wire step = (tick_r == 16'(QTR - 1));
    wire last_q = (q_r == 2'h3);
    // Address bytes carry the fixed seven-bit target address and the read/write bit.
    wire [7:0] addr_w = {gsr_pkg::TARGET_ADDR, 1'b0};
    wire [7:0] addr_r = {gsr_pkg::TARGET_ADDR, 1'b1};
    wire [7:0] next_byte = (idx_r == 2'h0) ? reg_r :
                           (idx_r == 2'h1) ? (write_r ? wdata_r : addr_r) : 8'hff;
    wire last_byte = write_r ? (idx_r == 2'h2) : (idx_r == 2'h3);
    wire is_rx = ~write_r & (idx_r == 2'h3);
    wire got_nack = rx_r[0] & ~is_rx;

    assign pins.scl_h_o = 1'b0;
    assign pins.scl_h_oe = scl_oe_r;
    assign pins.sda_h_o = 1'b0;
    assign pins.sda_h_oe = sda_oe_r;
    assign cmd_ready_o = (state_r == H_IDLE);
    assign rsp_valid_o = rsp_r;
    assign rsp_nack_o = nack_r;
    assign rsp_rdata_o = rdata_r;
    assign irq_o = ~pins.int_n;

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state_r <= H_IDLE;
            tick_r <= 16'h0000;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            idx_r <= 2'h0;
            tx_r <= 9'h1ff;
            rx_r <= 9'h000;
            write_r <= 1'b0;
            reg_r <= 8'h00;
            wdata_r <= 8'h00;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            nack_r <= 1'b0;
            rsp_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            rsp_r <= 1'b0;
            tick_r <= (state_r == H_IDLE || step) ? 16'h0000 : tick_r + 16'h0001;
            if (state_r != H_IDLE && step)
                q_r <= q_r + 2'h1;
            case (state_r)
                H_IDLE:
                    if (cmd_valid_i)
                    begin
                        write_r <= cmd_write_i;
                        reg_r <= cmd_reg_i;
                        wdata_r <= cmd_wdata_i;
                        idx_r <= 2'h0;
                        tx_r <= {addr_w, 1'b1};
                        nack_r <= 1'b0;
                        q_r <= 2'h0;
                        state_r <= H_START;
                    end
                // Start or repeated start: free SDA, free SCL, pull SDA, pull SCL.
                H_START:
                    if (step)
                    begin
                        case (q_r)
                            2'h0: sda_oe_r <= 1'b0;
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: sda_oe_r <= 1'b1;
                            default:
                            begin
                                scl_oe_r <= 1'b1;
                                bit_r <= 4'h0;
                                state_r <= H_BIT;
                            end
                        endcase
                    end
                H_BIT:
                    if (step)
                    begin
                        case (q_r)
                            2'h0: sda_oe_r <= ~tx_r[8];
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: rx_r <= {rx_r[7:0], pins.sda};
                            default:
                            begin
                                scl_oe_r <= 1'b1;
                                tx_r <= {tx_r[7:0], 1'b1};
                                bit_r <= bit_r + 4'h1;
                            end
                        endcase
                        if (last_q && bit_r == 4'h8)
                        begin
                            if (is_rx)
                                rdata_r <= rx_r[8:1];
                            if (got_nack || last_byte)
                            begin
                                nack_r <= got_nack;
                                state_r <= H_STOP;
                            end
                            else
                            begin
                                idx_r <= idx_r + 2'h1;
                                tx_r <= {next_byte, 1'b1};
                                bit_r <= 4'h0;
                                // A read re-addresses the target before the data byte.
                                state_r <= (~write_r && idx_r == 2'h1) ? H_START : H_BIT;
                            end
                        end
                    end
                H_STOP:
                    if (step)
                    begin
                        case (q_r)
                            2'h0: sda_oe_r <= 1'b1;
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: sda_oe_r <= 1'b0;
                            default:
                            begin
                                rsp_r <= 1'b1;
                                state_r <= H_IDLE;
                            end
                        endcase
                    end
                default:
                    state_r <= H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: testbench/gsr_link_sva.sv */
// Pin-level checks on the wires that join the host and the sensor.
`timescale 1ns/1ps
`default_nettype none
module gsr_link_sva (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Host pins
    input wire logic scl_h_o,
    input wire logic scl_h_oe,
    input wire logic sda_h_o,
    input wire logic sda_h_oe,
    // Sensor pins
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic int_d_o,
    input wire logic int_d_oe,
    // Resolved wires
    input wire logic scl,
    input wire logic sda,
    input wire logic int_n
);
    od_low_only_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !scl_h_o && !sda_h_o && !sda_d_o && !int_d_o)
        else $error("open-drain output drives high");
    rst_release_a: assert property (@(posedge sys_clk_i) srst_i |=>
        !scl_h_oe && !sda_h_oe && !sda_d_oe && !int_d_oe)
        else $error("pins not released in reset");
    dev_edge_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $changed(sda_d_oe) |-> !scl)
        else $error("sensor moved data while clock high");
    start_quiet_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $fell(sda) && scl && $past(scl) |-> !sda_d_oe [*8])
        else $error("sensor drives data after start");
    stop_quiet_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $rose(sda) && scl && $past(scl) |-> !sda_d_oe)
        else $error("sensor drives data at stop");
    scl_low_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $fell(scl) |-> !scl [*4])
        else $error("clock low phase too short");
    scl_high_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $rose(scl) |-> scl [*4])
        else $error("clock high phase too short");
    int_pin_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        int_n == !int_d_oe)
        else $error("interrupt wire disagrees with its driver");
endmodule
`default_nettype wire

/* File: testbench/gesture_sensor_register_map_tb.sv */
// Self-checking bench for the sensor register bank and its host.
`timescale 1ns/1ps
`default_nettype none
module gesture_sensor_register_map_tb;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic prox_mode_i = 1'b0;
    logic gesture_mode_i = 1'b1;
    logic [7:0] prox_data_i = 8'h00;
    logic [7:0] gesture_set_i = 8'h00;
    logic [7:0] gprox_set_i = 8'h00;
    logic [7:0] gesture_state_i = 8'h5a;
    logic [7:0] brightness_i = 8'hff;
    logic [9:0] size_i = 10'h384;
    logic cmd_valid_i = 1'b0;
    logic cmd_write_i = 1'b0;
    logic [7:0] cmd_reg_i = 8'h00;
    logic [7:0] cmd_wdata_i = 8'h00;
    logic cmd_ready_o, rsp_valid_o, rsp_nack_o, irq_o, suspend_o, approach_o;
    logic [7:0] rsp_rdata_o;
    logic [7:0] prox_gain_o;
    int fails = 0;
    int total_checks = 0;
    gsr_if link ();
    always #25 sys_clk_i = ~sys_clk_i;
    gsr_device i_gsr_device (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .pins(link),
        .prox_mode_i(prox_mode_i), .gesture_mode_i(gesture_mode_i), .prox_data_i(prox_data_i),
        .gesture_set_i(gesture_set_i), .gprox_set_i(gprox_set_i),
        .gesture_state_i(gesture_state_i), .brightness_i(brightness_i), .size_i(size_i),
        .suspend_o(suspend_o), .approach_o(approach_o), .prox_gain_o(prox_gain_o));
    gsr_host #(.QTR(4)) i_gsr_host (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .pins(link),
        .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_reg_i(cmd_reg_i),
        .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_nack_o(rsp_nack_o), .rsp_rdata_o(rsp_rdata_o), .irq_o(irq_o));
    gsr_link_sva i_gsr_link_sva (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .scl_h_o(link.scl_h_o), .scl_h_oe(link.scl_h_oe), .sda_h_o(link.sda_h_o),
        .sda_h_oe(link.sda_h_oe), .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe),
        .int_d_o(link.int_d_o), .int_d_oe(link.int_d_oe), .scl(link.scl),
        .sda(link.sda), .int_n(link.int_n));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One command on the host port, waited out under a bound.
    task automatic xfer(input logic wr, input logic [7:0] rg, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_write_i <= wr;
        cmd_reg_i <= rg;
        cmd_wdata_i <= wd;
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b0;
        @(negedge sys_clk_i);
        check({7'h00, cmd_ready_o}, 8'h00);
        while (rsp_valid_o !== 1'b1 && n < 3000)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        if (n >= 3000)
        begin
            fails++;
            report_and_stop();
        end
        check({7'h00, rsp_nack_o}, 8'h00);
        check({7'h00, cmd_ready_o}, 8'h01);
    endtask

    task automatic wr(input logic [7:0] rg, input logic [7:0] wd);
        xfer(1'b1, rg, wd);
    endtask

    task automatic rd(input logic [7:0] rg, input logic [7:0] exp);
        xfer(1'b0, rg, 8'h00);
        check(rsp_rdata_o, exp);
    endtask

    task automatic drive_prox(input logic [7:0] v);
        @(posedge sys_clk_i);
        prox_mode_i <= 1'b1;
        prox_data_i <= v;
        repeat (3) @(negedge sys_clk_i);
    endtask

    task automatic pulse(input logic [7:0] g, input logic [7:0] gp);
        @(posedge sys_clk_i);
        gesture_set_i <= g;
        gprox_set_i <= gp;
        @(posedge sys_clk_i);
        gesture_set_i <= 8'h00;
        gprox_set_i <= 8'h00;
        repeat (3) @(negedge sys_clk_i);
    endtask

    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(8'h03, 8'h01);
        rd(8'h41, 8'hff);
        rd(8'h42, 8'hff);
        rd(8'h69, 8'hc8);
        rd(8'h6a, 8'h40);
        rd(8'hef, 8'h00);
        check(prox_gain_o, 8'ha0);
        $display("test defaults done");
        wr(8'h69, 8'h80);
        wr(8'h6a, 8'h20);
        rd(8'h69, 8'h80);
        rd(8'h6a, 8'h20);
        drive_prox(8'h80);
        check({7'h00, approach_o}, 8'h01);
        rd(8'h6b, 8'h01);
        rd(8'h6c, 8'h80);
        drive_prox(8'h21);
        check({7'h00, approach_o}, 8'h01);
        drive_prox(8'h20);
        check({7'h00, approach_o}, 8'h00);
        rd(8'h6b, 8'h00);
        drive_prox(8'h7f);
        check({7'h00, approach_o}, 8'h00);
        wr(8'h6c, 8'h11);
        rd(8'h6c, 8'h7f);
        @(posedge sys_clk_i);
        prox_mode_i <= 1'b0;
        prox_data_i <= 8'hff;
        repeat (3) @(negedge sys_clk_i);
        check({7'h00, approach_o}, 8'h00);
        wr(8'h45, 8'h00);
        rd(8'h45, 8'h5a);
        @(posedge sys_clk_i);
        gesture_mode_i <= 1'b0;
        rd(8'h45, 8'h00);
        rd(8'hb0, 8'hff);
        rd(8'hb1, 8'h84);
        rd(8'hb2, 8'h03);
        $display("test proximity and readouts done");
        pulse(8'h01, 8'h00);
        check({7'h00, irq_o}, 8'h01);
        rd(8'h43, 8'h01);
        check({7'h00, irq_o}, 8'h00);
        wr(8'h41, 8'h00);
        pulse(8'h80, 8'h00);
        check({7'h00, irq_o}, 8'h00);
        rd(8'h43, 8'h80);
        pulse(8'h00, 8'h02);
        check({7'h00, irq_o}, 8'h01);
        rd(8'h44, 8'h02);
        check({7'h00, irq_o}, 8'h00);
        $display("test interrupts done");
        wr(8'hef, 8'h01);
        wr(8'h44, 8'h55);
        check(prox_gain_o, 8'h55);
        rd(8'h44, 8'h55);
        rd(8'hef, 8'h01);
        rd(8'h69, 8'h00);
        wr(8'hef, 8'h00);
        rd(8'h44, 8'h00);
        rd(8'h69, 8'h80);
        $display("test banks done");
        wr(8'h03, 8'h01);
        check({7'h00, suspend_o}, 8'h01);
        rd(8'h03, 8'h01);
        check({7'h00, suspend_o}, 8'h00);
        $display("test suspend done");
        wr(8'hef, 8'h01);
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(8'hef, 8'h00);
        check(prox_gain_o, 8'ha0);
        rd(8'h69, 8'hc8);
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
